// ===== design/rtc_cfg_pkg.sv
// Package for the real-time clock configuration, alarm and pointer block.
// Assumes one core clock; offsets, field positions and the byte and pointer reset values live here.
package rtc_cfg_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'hA1;
  localparam logic [7:0] ADDR_ALARM_ENABLE = 8'hA2;
  localparam logic [7:0] ADDR_POINTER = 8'hA3;
  localparam logic [7:0] ADDR_DATA = 8'hA4;
  localparam logic [7:0] ADDR_KEY = 8'hC1;
  localparam logic [7:0] ADDR_COMP = 8'hF6;
  // Clock configuration field positions
  localparam int ALARM_FLAG_BIT = 6;
  localparam int TIMEBASE_HI = 5;
  localparam int TIMEBASE_LO = 4;
  localparam int ONE_SHOT_BIT = 3;
  localparam int INTERVAL_FLAG_BIT = 2;
  localparam int TIMER_ON_BIT = 1;
  // Pointer fields
  localparam int WRITE_SEL_BIT = 7;
  localparam int PTR_ADDR_HI = 4;
  // Alarm enable width (second, minute, hour, weekday, date)
  localparam int MATCH_FIELDS = 5;
  // Internal register addresses
  localparam logic [4:0] IADDR_SUB_SEC = 5'h01;
  localparam logic [4:0] IADDR_SEC = 5'h02;
  localparam logic [4:0] IADDR_YEAR = 5'h08;
  localparam logic [4:0] IADDR_INTERVAL = 5'h09;
  localparam logic [4:0] IADDR_ALARM_SEC = 5'h0A;
  localparam logic [4:0] IADDR_ALARM_DATE = 5'h0E;
  // Unlock key and reset values
  localparam logic [7:0] UNLOCK_KEY = 8'hEA;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] RESET_PTR = 5'h00;
  // Timebase encodings
  localparam logic [1:0] TB_TICK = 2'h0;
  localparam logic [1:0] TB_SEC = 2'h1;
  localparam logic [1:0] TB_MIN = 2'h2;
  localparam logic [1:0] TB_HOUR = 2'h3;
  // Prescaler terminal counts (128 ticks a second, 60 of a unit)
  localparam logic [6:0] TICKS_LAST = 7'h7F;
  localparam logic [5:0] SIXTY_LAST = 6'h3B;
endpackage : rtc_cfg_pkg

// ===== design/rtc_config_alarm_pointer.sv
// Configuration, interval timer, alarm match and keyed indirect access of the RTC.
// Assumes the core special function register bus on ref_clk, a 128 Hz square wave
// from the crystal domain, and time counters that change only on its rising edge.
//
// Summary of operation
// - Alarm flag, bit 6, set when at least one field is enabled and every enabled one equals its alarm value.
// - Software clears the alarm flag; it stays set until then.
// - Bits 5:4 pick the interval unit: tick, second, minute or hour.
// - Interval flag, bit 2, set when the interval elapses; software clears it.
// - One-shot off: flag after each interval, counting restarts at once.
// - One-shot on: flag after a single interval, no rearm.
// - Timer-on low stops the timer and holds its 8-bit counter in reset.
// - Second-match enable compares second alarm 0x0A with seconds 0x02.
// - Minute-match enable compares minute alarm 0x0B with minutes 0x03.
// - Hour-match enable compares hour alarm 0x0C with hours 0x04.
// - Weekday-match enable compares weekday alarm 0x0D with weekday 0x05.
// - Date-match enable compares date alarm 0x0E with date 0x06.
// - Alarm needs all enabled fields matching; flag set raises interrupt if enabled.
// - Pointer write with bit 7 low copies the addressed register to data.
// - Pointer write with bit 7 high moves data into the addressed register.
// - Indirect write only with key 0xEA written just before.
// - Pointer holds 5-bit address, reset 0; data register is 8 bits, reset 0.
// - Compensation register holds the 8-bit crystal correction, default 0.
// - Compensation register returns to default on every reset.
// - Key register clears to 0 after a timekeeping write.
// - Config and interval value land on the 128 Hz update.
// - Interval flag set when the count equals the interval value.
`timescale 1ns/1ps
module rtc_config_alarm_pointer
  import rtc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  input wire logic tick128,
  input wire logic [7:0] subSecIn,
  input wire logic [7:0] secIn,
  input wire logic [7:0] minIn,
  input wire logic [7:0] hourIn,
  input wire logic [7:0] weekdayIn,
  input wire logic [7:0] dateIn,
  input wire logic [7:0] monthIn,
  input wire logic [7:0] yearIn,
  output logic timeWrStrobe,
  output logic [4:0] timeWrAddr,
  output logic [7:0] timeWrData,
  input wire logic rtcIrqEnable,
  output logic rtcIrq,
  output logic [7:0] compValue
);

  ////////////////////////////////////////////////////////////////////////////
  // Core-side registers
  logic alarm_match_flag;
  logic interval_elapsed_flag;
  logic [1:0] interval_timebase_sel;
  logic interval_one_shot;
  logic interval_timer_on;
  logic [MATCH_FIELDS-1:0] matchOn;
  logic [4:0] pointerAddr;
  logic indirect_write_sel;
  logic [7:0] indirectData;
  logic [7:0] unlock_key_reg;
  logic keyLive;
  logic [7:0] interval_compare_value;
  logic [7:0] alarmValue [MATCH_FIELDS];
  logic [7:0] snap [8];
  // Active copies seen by the timer and comparators
  logic [1:0] actTimebase;
  logic actOneShot;
  logic actTimerOn;
  logic [MATCH_FIELDS-1:0] actMatchOn;
  logic [7:0] actInterval;
  // Timer state
  logic [6:0] tickCount;
  logic [5:0] secCount;
  logic [5:0] minCount;
  logic [7:0] intervalCount;
  logic oneShotDone;
  logic matchPrev;
  // Synchroniser for the 128 Hz wave
  logic tickS1, tickS2, tickS3, tickLevel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire wrConfig = sfrWr && sfrAddr == ADDR_CLOCK_CONFIG;
  wire wrMatch = sfrWr && sfrAddr == ADDR_ALARM_ENABLE;
  wire wrPointer = sfrWr && sfrAddr == ADDR_POINTER;
  wire wrData = sfrWr && sfrAddr == ADDR_DATA;
  wire wrKey = sfrWr && sfrAddr == ADDR_KEY;
  wire wrComp = sfrWr && sfrAddr == ADDR_COMP;
  wire [4:0] ptrNew = sfrWrData[PTR_ADDR_HI:0];
  wire ptrIsWrite = sfrWrData[WRITE_SEL_BIT];
  // Key must be written with only the data write in between
  wire writeAllowed = keyLive && unlock_key_reg == UNLOCK_KEY;
  wire indWrite = wrPointer && ptrIsWrite && writeAllowed;
  wire indRead = wrPointer && !ptrIsWrite;
  wire newIsInterval = ptrNew == IADDR_INTERVAL;
  wire newIsAlarm = ptrNew >= IADDR_ALARM_SEC && ptrNew <= IADDR_ALARM_DATE;
  wire newIsTime = ptrNew >= IADDR_SUB_SEC && ptrNew <= IADDR_YEAR;
  wire [2:0] newAlarmIdx = 3'(ptrNew - IADDR_ALARM_SEC);
  wire [2:0] newTimeIdx = 3'(ptrNew - IADDR_SUB_SEC);

  // Indirect read source for the freshly written pointer address
  wire [7:0] indReadValue = newIsTime ? snap[newTimeIdx] :
                            newIsInterval ? interval_compare_value :
                            newIsAlarm ? alarmValue[newAlarmIdx] : RESET_BYTE;

  // Read-back mux; reserved and unused bits read as zero
  wire [7:0] configRead = {1'b0, alarm_match_flag, interval_timebase_sel, interval_one_shot,
                           interval_elapsed_flag, interval_timer_on, 1'b0};
  wire [7:0] readMux = sfrAddr == ADDR_CLOCK_CONFIG ? configRead :
                       sfrAddr == ADDR_ALARM_ENABLE ? {3'h0, matchOn} :
                       sfrAddr == ADDR_POINTER ? {indirect_write_sel, 2'h0, pointerAddr} :
                       sfrAddr == ADDR_DATA ? indirectData :
                       sfrAddr == ADDR_KEY ? unlock_key_reg :
                       sfrAddr == ADDR_COMP ? compValue : RESET_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // 128 Hz tick: three flops, counted once second and third agree
  wire tickAgree = tickS2 == tickS3;
  wire tickEdge = tickAgree && tickS3 && !tickLevel;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tickS1 <= 1'b0;
      tickS2 <= 1'b0;
      tickS3 <= 1'b0;
      tickLevel <= 1'b0;
    end else if (clkEn) begin
      tickS1 <= tick128;
      tickS2 <= tickS1;
      tickS3 <= tickS2;
      if (tickAgree) begin
        tickLevel <= tickS3;
      end
    end
  end

  // Time snapshot taken once the tick edge is settled, counters are quiet then
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        snap[i] <= RESET_BYTE;
      end
    end else if (clkEn && tickEdge) begin
      snap[0] <= subSecIn;
      snap[1] <= secIn;
      snap[2] <= minIn;
      snap[3] <= hourIn;
      snap[4] <= weekdayIn;
      snap[5] <= dateIn;
      snap[6] <= monthIn;
      snap[7] <= yearIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and compensation registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      interval_timebase_sel <= TB_TICK;
      interval_one_shot <= 1'b0;
      interval_timer_on <= 1'b0;
      matchOn <= '0;
      compValue <= RESET_BYTE;
    end else if (clkEn) begin
      if (wrConfig) begin
        interval_timebase_sel <= sfrWrData[TIMEBASE_HI:TIMEBASE_LO];
        interval_one_shot <= sfrWrData[ONE_SHOT_BIT];
        interval_timer_on <= sfrWrData[TIMER_ON_BIT];
      end
      if (wrMatch) begin
        matchOn <= sfrWrData[MATCH_FIELDS-1:0];
      end
      if (wrComp) begin
        compValue <= sfrWrData;
      end
    end
  end

  // Pointer, data, key and indirect targets
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pointerAddr <= RESET_PTR;
      indirect_write_sel <= 1'b0;
      indirectData <= RESET_BYTE;
      unlock_key_reg <= RESET_BYTE;
      keyLive <= 1'b0;
      interval_compare_value <= RESET_BYTE;
      for (int i = 0; i < MATCH_FIELDS; i++) begin
        alarmValue[i] <= RESET_BYTE;
      end
    end else if (clkEn) begin
      if (wrPointer) begin
        pointerAddr <= ptrNew;
        indirect_write_sel <= ptrIsWrite;
      end
      if (indRead) begin
        indirectData <= indReadValue;
      end else if (wrData) begin
        indirectData <= sfrWrData;
      end
      // Any write other than data between key and pointer disarms the key
      if (wrKey) begin
        unlock_key_reg <= sfrWrData;
        keyLive <= 1'b1;
      end else if (wrPointer) begin
        unlock_key_reg <= RESET_BYTE;
        keyLive <= 1'b0;
      end else if (sfrWr && !wrData) begin
        keyLive <= 1'b0;
      end
      if (indWrite && newIsInterval) begin
        interval_compare_value <= indirectData;
      end
      if (indWrite && newIsAlarm) begin
        alarmValue[newAlarmIdx] <= indirectData;
      end
    end
  end

  // Timekeeping writes go out to the counter chain as one pulse
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      timeWrStrobe <= 1'b0;
      timeWrAddr <= RESET_PTR;
      timeWrData <= RESET_BYTE;
    end else if (clkEn) begin
      timeWrStrobe <= indWrite && newIsTime;
      if (indWrite && newIsTime) begin
        timeWrAddr <= ptrNew;
        timeWrData <= indirectData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active copies refresh on each tick, so a write lands within one tick
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      actTimebase <= TB_TICK;
      actOneShot <= 1'b0;
      actTimerOn <= 1'b0;
      actMatchOn <= '0;
      actInterval <= RESET_BYTE;
    end else if (clkEn && tickEdge) begin
      actTimebase <= interval_timebase_sel;
      actOneShot <= interval_one_shot;
      actTimerOn <= interval_timer_on;
      actMatchOn <= matchOn;
      actInterval <= interval_compare_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval prescaler and counter
  wire secPulse = tickEdge && tickCount == TICKS_LAST;
  wire minPulse = secPulse && secCount == SIXTY_LAST;
  wire hourPulse = minPulse && minCount == SIXTY_LAST;
  wire unitPulse = actTimebase == TB_TICK ? tickEdge :
                   actTimebase == TB_SEC ? secPulse :
                   actTimebase == TB_MIN ? minPulse : hourPulse;
  wire [7:0] next_intervalCount = 8'(intervalCount + 8'h01);
  wire intervalHit = actTimerOn && !oneShotDone && unitPulse &&
                     next_intervalCount == actInterval;

  always_ff @(posedge ref_clk) begin
    if (!resetn || (clkEn && !actTimerOn)) begin
      tickCount <= '0;
      secCount <= '0;
      minCount <= '0;
      intervalCount <= RESET_BYTE;
      oneShotDone <= 1'b0;
    end else if (clkEn) begin
      if (tickEdge) begin
        tickCount <= 7'(tickCount + 7'h01);
      end
      if (secPulse) begin
        secCount <= secCount == SIXTY_LAST ? 6'h00 : 6'(secCount + 6'h01);
      end
      if (minPulse) begin
        minCount <= minCount == SIXTY_LAST ? 6'h00 : 6'(minCount + 6'h01);
      end
      if (intervalHit) begin
        intervalCount <= RESET_BYTE;
        oneShotDone <= actOneShot;
      end else if (unitPulse && !oneShotDone) begin
        intervalCount <= next_intervalCount;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm comparators: snapshot fields 1..5 are second..date
  logic [MATCH_FIELDS-1:0] fieldOk;
  genvar g;
  generate
    for (g = 0; g < MATCH_FIELDS; g++) begin : g_match
      assign fieldOk[g] = !actMatchOn[g] || snap[g+1] == alarmValue[g];
    end
  endgenerate
  // Only a new match fires, so a cleared flag is not re-set at once
  wire allMatch = |actMatchOn && &fieldOk;
  wire alarmHit = allMatch && !matchPrev;

  // Flags: a hardware set wins over a software clear in the same cycle
  wire clearAlarm = wrConfig && !sfrWrData[ALARM_FLAG_BIT];
  wire clearInterval = wrConfig && !sfrWrData[INTERVAL_FLAG_BIT];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      alarm_match_flag <= 1'b0;
      interval_elapsed_flag <= 1'b0;
      matchPrev <= 1'b0;
      rtcIrq <= 1'b0;
      sfrRdData <= RESET_BYTE;
    end else if (clkEn) begin
      matchPrev <= allMatch;
      if (alarmHit) begin
        alarm_match_flag <= 1'b1;
      end else if (clearAlarm) begin
        alarm_match_flag <= 1'b0;
      end
      if (intervalHit) begin
        interval_elapsed_flag <= 1'b1;
      end else if (clearInterval) begin
        interval_elapsed_flag <= 1'b0;
      end
      rtcIrq <= rtcIrqEnable && (alarmHit || intervalHit);
      if (sfrRd) begin
        sfrRdData <= readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_alarm_hit;
    clkEn && alarmHit;
  endsequence
  property p_alarm_set;
    @(posedge ref_clk) disable iff (!resetn) s_alarm_hit |=> alarm_match_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set on match");
  property p_alarm_holds;
    @(posedge ref_clk) disable iff (!resetn)
      alarm_match_flag && !(clkEn && clearAlarm) |=> alarm_match_flag;
  endproperty
  a_alarm_holds: assert property (p_alarm_holds) else $error("alarm flag dropped without clear");
  property p_interval_set;
    @(posedge ref_clk) disable iff (!resetn)
      clkEn && unitPulse && actTimerOn && !oneShotDone && next_intervalCount == actInterval
      |=> interval_elapsed_flag && intervalCount == 8'h00;
  endproperty
  a_interval_set: assert property (p_interval_set) else $error("interval flag missed");
  property p_one_shot;
    @(posedge ref_clk) disable iff (!resetn)
      clkEn && intervalHit && actOneShot ##1 actTimerOn |-> !intervalHit;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot rearmed");
  property p_timer_off;
    @(posedge ref_clk) disable iff (!resetn) clkEn && !actTimerOn |=> intervalCount == 8'h00;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("counter not held while off");
  property p_no_key_no_write;
    @(posedge ref_clk) disable iff (!resetn)
      clkEn && wrPointer && ptrIsWrite && unlock_key_reg != UNLOCK_KEY |=> !timeWrStrobe;
  endproperty
  a_no_key_no_write: assert property (p_no_key_no_write) else $error("write without key");
  property p_key_cleared;
    @(posedge ref_clk) disable iff (!resetn) clkEn && wrPointer |=> unlock_key_reg == 8'h00;
  endproperty
  a_key_cleared: assert property (p_key_cleared) else $error("key not cleared");
  property p_read_copy;
    @(posedge ref_clk) disable iff (!resetn)
      clkEn && indRead && newIsInterval |=> indirectData == $past(interval_compare_value);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("indirect read wrong");
  property p_config_lands;
    @(posedge ref_clk) disable iff (!resetn)
      clkEn && tickEdge |=> actTimerOn == $past(interval_timer_on);
  endproperty
  a_config_lands: assert property (p_config_lands) else $error("config not landed on tick");
  property p_irq;
    @(posedge ref_clk) disable iff (!resetn) s_alarm_hit and rtcIrqEnable |=> rtcIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing on alarm");

endmodule : rtc_config_alarm_pointer

// ===== testbench/rtc_time_model.sv
// Crystal-side partner: tick source and the eight time counters.
// Assumes the bench asks for each tick with a one-cycle tickReq pulse.
`timescale 1ns/1ps
module rtc_time_model (
  input wire logic ref_clk,
  input wire logic tickReq,
  input wire logic timeWrStrobe,
  input wire logic [4:0] timeWrAddr,
  input wire logic [7:0] timeWrData,
  output logic tick128,
  output logic [8:1][7:0] cnt
);
  logic [8:1][7:0] pend;
  logic [8:1] pendOn;
  logic [3:0] highCnt;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick128 = 1'b0;
    cnt = '0;
    pend = '0;
    pendOn = '0;
    highCnt = 4'h0;
  end
  // Writes wait for the tick, so counters never move between ticks
  always @(posedge ref_clk) begin
    if (tickReq) begin
      tick128 <= 1'b1;
      highCnt <= 4'h6;
      for (int i = 1; i <= 8; i++) if (pendOn[i]) cnt[i] <= pend[i];
      pendOn <= '0;
    end else if (highCnt != 4'h0) begin
      highCnt <= highCnt - 4'h1;
    end else begin
      tick128 <= 1'b0;
    end
    // Last, so a write beside a tick waits for the next one instead of being lost
    if (timeWrStrobe && timeWrAddr >= 5'h01 && timeWrAddr <= 5'h08) begin
      pend[timeWrAddr] <= timeWrData;
      pendOn[timeWrAddr] <= 1'b1;
    end
  end
endmodule : rtc_time_model

// ===== testbench/tb_rtc_config_alarm_pointer.sv
// Self-checking bench for the RTC configuration, alarm and pointer block.
// Assumes the design package and the crystal-side partner model.
`timescale 1ns/1ps
module tb_rtc_config_alarm_pointer;
  import rtc_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic tickReq = 1'b0;
  logic rtcIrqEnable = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] sfrRdData;
  logic [7:0] timeWrData;
  logic [7:0] compValue;
  logic [7:0] lastData;
  logic [7:0] regList [5] = '{ADDR_CLOCK_CONFIG, ADDR_ALARM_ENABLE, ADDR_POINTER, ADDR_DATA, ADDR_COMP};
  logic [4:0] timeWrAddr;
  logic [4:0] lastAddr;
  logic timeWrStrobe;
  logic rtcIrq;
  logic tick128;
  logic [8:1][7:0] cnt;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int nStrobe = 0;
  int nIrq = 0;
  int n0;
  int k;
  ////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 ref_clk = ~ref_clk;
  rtc_config_alarm_pointer dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .tick128(tick128),
    .subSecIn(cnt[1]), .secIn(cnt[2]), .minIn(cnt[3]), .hourIn(cnt[4]), .weekdayIn(cnt[5]),
    .dateIn(cnt[6]), .monthIn(cnt[7]), .yearIn(cnt[8]), .timeWrStrobe(timeWrStrobe),
    .timeWrAddr(timeWrAddr), .timeWrData(timeWrData), .rtcIrqEnable(rtcIrqEnable), .rtcIrq(rtcIrq),
    .compValue(compValue));
  rtc_time_model partner (.ref_clk(ref_clk), .tickReq(tickReq), .timeWrStrobe(timeWrStrobe),
    .timeWrAddr(timeWrAddr), .timeWrData(timeWrData), .tick128(tick128), .cnt(cnt));
  // Pulse counters and the hang guard; a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (timeWrStrobe === 1'b1) begin
      nStrobe <= nStrobe + 1;
      lastAddr <= timeWrAddr;
      lastData <= timeWrData;
    end
    if (rtcIrq === 1'b1) nIrq <= nIrq + 1;
    if (cycles == 60000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chkN(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkN
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWr <= 1'b1;
    @(posedge ref_clk);
    sfrWr <= 1'b0;
  endtask : wr
  // Data is registered on the taken edge; sample after the next one
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge ref_clk);
    sfrRd <= 1'b0;
    @(posedge ref_clk);
    #1 d = sfrRdData;
  endtask : rdReg
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rdReg(a, d);
    chk8(what, exp, d);
  endtask : rdChk
  // Key, data, then pointer with the write select set
  task automatic wrInd(input logic [4:0] a, input logic [7:0] d);
    wr(ADDR_KEY, UNLOCK_KEY);
    wr(ADDR_DATA, d);
    wr(ADDR_POINTER, {3'b100, a});
    repeat (3) @(posedge ref_clk);
  endtask : wrInd
  task automatic rdInd(input logic [4:0] a, input logic [7:0] exp, input string what);
    wr(ADDR_POINTER, {3'b000, a});
    rdChk(ADDR_DATA, exp, what);
  endtask : rdInd
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tickReq <= 1'b1;
      @(posedge ref_clk);
      tickReq <= 1'b0;
      repeat (12) @(posedge ref_clk);
    end
  endtask : tick
  // Ticks until the interval flag shows, at most lim
  task automatic waitFlag(input int lim, output int n);
    logic [7:0] d;
    n = 0;
    d = 8'h00;
    while (d[INTERVAL_FLAG_BIT] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
      rdReg(ADDR_CLOCK_CONFIG, d);
    end
  endtask : waitFlag
  task automatic doReset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : doReset
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    doReset();
    // Reset values, unmapped read, compensation register
    foreach (regList[i])
      rdChk(regList[i], 8'h00, "resetVal");
    rdChk(8'h90, 8'h00, "unmapped");
    wr(ADDR_COMP, 8'h5A);
    rdChk(ADDR_COMP, 8'h5A, "comp");
    chk8("compValue", 8'h5A, compValue);
    wr(ADDR_POINTER, 8'h05);
    rdChk(ADDR_POINTER, 8'h05, "pointer");
    wr(ADDR_CLOCK_CONFIG, 8'h30);
    rdChk(ADDR_CLOCK_CONFIG, 8'h30, "timebase");
    doReset();
    rdChk(ADDR_COMP, 8'h00, "compAfterReset");
    chk8("compValueReset", 8'h00, compValue);
    // Clock enable low: a write must not land
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(ADDR_COMP, 8'hA5);
    clkEn <= 1'b1;
    rdChk(ADDR_COMP, 8'h00, "frozenComp");
    rdChk(ADDR_POINTER, 8'h00, "pointerReset");
    // Keyed write reaches the counters, key then clears
    n0 = nStrobe;
    wrInd(5'h04, 8'h23);
    chkN("strobes", n0 + 1, nStrobe);
    chk8("strobeAddr", 8'h04, {3'h0, lastAddr});
    chk8("strobeData", 8'h23, lastData);
    rdChk(ADDR_KEY, 8'h00, "keyCleared");
    // No key, then a key spoilt by an unrelated write: both ignored
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_POINTER, 8'h84);
    wr(ADDR_KEY, UNLOCK_KEY);
    wr(ADDR_ALARM_ENABLE, 8'h00);
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_POINTER, 8'h84);
    repeat (3) @(posedge ref_clk);
    chkN("lockedStrobes", n0 + 1, nStrobe);
    // Each alarm field alone: mismatch, match, hold, clear
    for (int i = 0; i < 5; i++) begin
      wrInd(5'(IADDR_ALARM_SEC + i), 8'(8'h10 + i));
      rdInd(5'(IADDR_ALARM_SEC + i), 8'(8'h10 + i), "alarmValue");
      wrInd(5'(IADDR_SEC + i), 8'(8'h0F + i));
      wr(ADDR_ALARM_ENABLE, 8'h01 << i);
      wr(ADDR_CLOCK_CONFIG, 8'h00);
      tick(2);
      rdChk(ADDR_CLOCK_CONFIG, 8'h00, "alarmEarly");
      n0 = nIrq;
      wrInd(5'(IADDR_SEC + i), 8'(8'h10 + i));
      tick(1);
      rdInd(5'(IADDR_SEC + i), 8'(8'h10 + i), "timeRead");
      rdChk(ADDR_CLOCK_CONFIG, 8'h40, "alarmFlag");
      chkN("alarmIrq", n0 + 1, nIrq);
      tick(1);
      rdChk(ADDR_CLOCK_CONFIG, 8'h40, "alarmHeld");
      wr(ADDR_CLOCK_CONFIG, 8'h00);
      rdChk(ADDR_CLOCK_CONFIG, 8'h00, "alarmCleared");
    end
    // Two fields enabled: one match is not enough; no interrupt when disabled
    wrInd(5'h03, 8'h30);
    wr(ADDR_ALARM_ENABLE, 8'h03);
    tick(2);
    rdChk(ADDR_CLOCK_CONFIG, 8'h00, "partialMatch");
    rtcIrqEnable <= 1'b0;
    n0 = nIrq;
    wrInd(5'h03, 8'h11);
    tick(1);
    rdChk(ADDR_CLOCK_CONFIG, 8'h40, "fullMatch");
    chkN("maskedIrq", n0, nIrq);
    rtcIrqEnable <= 1'b1;
    wr(ADDR_ALARM_ENABLE, 8'h00);
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    // Repeating interval in ticks: exact spacing between flags
    wrInd(IADDR_INTERVAL, 8'h03);
    rdInd(IADDR_INTERVAL, 8'h03, "intervalValue");
    wr(ADDR_CLOCK_CONFIG, 8'h02);
    waitFlag(8, k);
    chkN("firstFire", 1, int'(k >= 3 && k <= 5));
    wr(ADDR_CLOCK_CONFIG, 8'h02);
    waitFlag(8, k);
    chkN("repeatTicks", 3, k);
    // One-shot after a stop: fires once, never rearms
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    tick(2);
    wr(ADDR_CLOCK_CONFIG, 8'h0A);
    waitFlag(8, k);
    chkN("oneShotFire", 1, int'(k >= 3 && k <= 5));
    wr(ADDR_CLOCK_CONFIG, 8'h0A);
    tick(8);
    rdChk(ADDR_CLOCK_CONFIG, 8'h0A, "noRearm");
    // Second timebase: one unit is 128 ticks
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    tick(2);
    wrInd(IADDR_INTERVAL, 8'h01);
    wr(ADDR_CLOCK_CONFIG, 8'h12);
    waitFlag(300, k);
    chkN("secondUnit", 1, int'(k >= 128 && k <= 258));
    test_done();
  end
endmodule : tb_rtc_config_alarm_pointer
